// ### rtl/itas_pkg.sv
package itas_pkg;

  // Fixed secondary-port addresses, 7-bit form
  localparam logic [6:0] ADDR_SEC_ONE = 7'h38;
  localparam logic [6:0] ADDR_SEC_TWO = 7'h3F;

  // Primary-port address: upper four bits fixed, bit 2 selects the context, low two from strap band
  localparam logic [3:0] ADDR_PRI_UPPER = 4'h4;
  localparam int ADDR_CODE_W = 3;
  localparam logic CODE_SEL_ONE = 1'b0;
  localparam logic CODE_SEL_TWO = 1'b1;

  // Address byte layout: direction in bit 0, address above it
  localparam int ADDR_RW_BIT = 0;
  localparam int ADDR_LSB = 1;
  localparam int ADDR_MSB = 7;

  // Bits per byte on the wire
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Strap ADC defaults and band upper limits in thousandths of full scale
  localparam int ADC_W_DEF = 10;
  localparam int PERMILLE = 1000;
  localparam int BAND0_MAX_PM = 180;
  localparam int BAND1_MAX_PM = 380;
  localparam int BAND2_MAX_PM = 580;

  // Events and interrupt defaults
  localparam int EV_W_DEF = 8;

endpackage

// ### rtl/itas_addr_if.sv
`timescale 1ns/10ps
`default_nettype none

interface itas_addr_if;
  logic [6:0] addr_one;
  logic [6:0] addr_two;
  logic ready;

  modport src (
    output addr_one,
    output addr_two,
    output ready
  );

  modport dst (
    input addr_one,
    input addr_two,
    input ready
  );
endinterface

`default_nettype wire

// ### rtl/itas_addr_select.sv
`timescale 1ns/10ps
`default_nettype none

module itas_addr_select #(
  parameter int ADC_W = itas_pkg::ADC_W_DEF,
  parameter bit USE_STRAP = 1'b1
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic strap_valid,
  input wire logic [ADC_W-1:0] address_strap_input,
  input wire logic [6:0] fw_mask_one,
  input wire logic [6:0] fw_value_one,
  input wire logic [6:0] fw_mask_two,
  input wire logic [6:0] fw_value_two,
  itas_addr_if.src aif
);

  localparam int FULL = (1 << ADC_W) - 1;
  localparam logic [ADC_W-1:0] TH0 =
    ADC_W'(itas_pkg::BAND0_MAX_PM * FULL / itas_pkg::PERMILLE);
  localparam logic [ADC_W-1:0] TH1 =
    ADC_W'(itas_pkg::BAND1_MAX_PM * FULL / itas_pkg::PERMILLE);
  localparam logic [ADC_W-1:0] TH2 =
    ADC_W'(itas_pkg::BAND2_MAX_PM * FULL / itas_pkg::PERMILLE);

  // Classify a strap reading into one of four bands
  function automatic logic [1:0] band_of(input logic [ADC_W-1:0] v);
    if (v <= TH0) begin
      band_of = 2'h0;
    end else if (v <= TH1) begin
      band_of = 2'h1;
    end else if (v <= TH2) begin
      band_of = 2'h2;
    end else begin
      band_of = 2'h3;
    end
  endfunction

  // Masked bits take the firmware value, others keep the default
  function automatic logic [6:0] apply_fw(input logic [6:0] dflt,
                                          input logic [6:0] mask,
                                          input logic [6:0] value);
    apply_fw = (dflt & ~mask) | (value & mask);
  endfunction

  logic [1:0] band_q, band_d;
  logic ready_q, ready_d;
  logic [6:0] dflt_one, dflt_two;

  // Latch the band once, then declare the addresses ready
  always_comb begin
    band_d = band_q;
    ready_d = ready_q;
    if (!ready_q) begin
      if (!USE_STRAP) begin
        ready_d = 1'b1;
      end else if (strap_valid) begin
        band_d = band_of(address_strap_input);
        ready_d = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      band_q <= 2'h0;
      ready_q <= 1'b0;
    end else begin
      band_q <= band_d;
      ready_q <= ready_d;
    end
  end

  // Default addresses per USB-C port context
  always_comb begin
    if (USE_STRAP) begin
      dflt_one = {itas_pkg::ADDR_PRI_UPPER, itas_pkg::CODE_SEL_ONE, band_q};
      dflt_two = {itas_pkg::ADDR_PRI_UPPER, itas_pkg::CODE_SEL_TWO, band_q};
    end else begin
      dflt_one = itas_pkg::ADDR_SEC_ONE;
      dflt_two = itas_pkg::ADDR_SEC_TWO;
    end
  end

  // Firmware-owned final addresses
  assign aif.addr_one = apply_fw(dflt_one, fw_mask_one, fw_value_one);
  assign aif.addr_two = apply_fw(dflt_two, fw_mask_two, fw_value_two);
  assign aif.ready = ready_q;

endmodule

`default_nettype wire

// ### rtl/itas_target.sv
// Functional notes
// - Secondary port defaults to 0111000 and 0111111
// - Upper seven bits address; bit 0 direction
// - Firmware masks and replaces each address bit
// - Matching uses firmware-writable addresses
// - Matched address steers to its port context
// - Sub-address byte selects register or command
// - Strap band sets primary address bits 1:0
// - Strap reading classified into four bands
// - Strap band latched before the port responds
// - Device stretches clock while awaiting read data
// - Per-port mask selects interrupting events
// - Works at standard and fast mode rates
`timescale 1ns/10ps
`default_nettype none

module itas_target #(
  parameter int ADC_W = itas_pkg::ADC_W_DEF,
  parameter bit USE_STRAP = 1'b1,
  parameter int EV_W = itas_pkg::EV_W_DEF
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic strap_valid,
  input wire logic [ADC_W-1:0] address_strap_input,
  input wire logic [6:0] fw_mask_one,
  input wire logic [6:0] fw_value_one,
  input wire logic [6:0] fw_mask_two,
  input wire logic [6:0] fw_value_two,
  output logic port_enabled,
  output logic wr_valid,
  output logic wr_ctx,
  output logic [7:0] wr_sub,
  output logic [7:0] wr_data,
  output logic rd_req,
  output logic rd_ctx,
  output logic [7:0] rd_sub,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  input wire logic [EV_W-1:0] irq_event,
  input wire logic [EV_W-1:0] irq_mask,
  output logic port_irq_n
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_SUB, ST_RX_ACK, ST_WDATA,
    ST_RWAIT, ST_RDATA, ST_RMACK, ST_IGNORE
  } itas_state_t;

  itas_addr_if aif ();

  itas_addr_select #(
    .ADC_W(ADC_W),
    .USE_STRAP(USE_STRAP)
  ) u_addr (
    .ref_clk(ref_clk),
    .reset(reset),
    .strap_valid(strap_valid),
    .address_strap_input(address_strap_input),
    .fw_mask_one(fw_mask_one),
    .fw_value_one(fw_value_one),
    .fw_mask_two(fw_mask_two),
    .fw_value_two(fw_value_two),
    .aif(aif)
  );

  // Two-stage synchronisers plus a delayed copy for edge detection
  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end else begin
      scl_s1_q <= scl_in;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_in;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end

  // Bus events; 10 ns sampling covers standard and fast mode
  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl_s2_q & ~scl_s3_q;
  assign scl_fall = ~scl_s2_q & scl_s3_q;
  assign bus_start = scl_s2_q & scl_s3_q & ~sda_s2_q & sda_s3_q;
  assign bus_stop = scl_s2_q & scl_s3_q & sda_s2_q & ~sda_s3_q;

  itas_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] sub_q, sub_d;
  logic [7:0] wdat_q, wdat_d;
  logic ctx_q, ctx_d;
  logic rw_q, rw_d;
  logic mack_q, mack_d;
  logic sda_oe_q, sda_oe_d;
  logic scl_oe_q, scl_oe_d;
  logic wr_valid_q, wr_valid_d;
  logic rd_req_q, rd_req_d;
  logic [6:0] rx_addr;

  assign rx_addr = sh_q[itas_pkg::ADDR_MSB:itas_pkg::ADDR_LSB];

  // Target protocol engine
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    sub_d = sub_q;
    wdat_d = wdat_q;
    ctx_d = ctx_q;
    rw_d = rw_q;
    mack_d = mack_q;
    sda_oe_d = sda_oe_q;
    scl_oe_d = scl_oe_q;
    wr_valid_d = 1'b0;
    rd_req_d = 1'b0;
    if (!aif.ready) begin
      state_d = ST_IDLE;
      sda_oe_d = 1'b0;
      scl_oe_d = 1'b0;
    end else if (bus_start) begin
      state_d = ST_ADDR;
      cnt_d = 4'h0;
      sda_oe_d = 1'b0;
      scl_oe_d = 1'b0;
    end else if (bus_stop) begin
      state_d = ST_IDLE;
      sda_oe_d = 1'b0;
      scl_oe_d = 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE, ST_IGNORE: begin
        end
        ST_ADDR, ST_SUB, ST_WDATA: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_s2_q};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == itas_pkg::BYTE_BITS) begin
            cnt_d = 4'h0;
            if (state_q == ST_ADDR) begin
              if (rx_addr == aif.addr_one || rx_addr == aif.addr_two) begin
                ctx_d = (rx_addr != aif.addr_one);
                rw_d = sh_q[itas_pkg::ADDR_RW_BIT];
                sda_oe_d = 1'b1;
                state_d = ST_ADDR_ACK;
              end else begin
                state_d = ST_IGNORE;
              end
            end else if (state_q == ST_SUB) begin
              sub_d = sh_q;
              sda_oe_d = 1'b1;
              state_d = ST_RX_ACK;
            end else begin
              wdat_d = sh_q;
              wr_valid_d = 1'b1;
              sda_oe_d = 1'b1;
              state_d = ST_RX_ACK;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            sda_oe_d = 1'b0;
            if (rw_q) begin
              rd_req_d = 1'b1;
              scl_oe_d = 1'b1;
              state_d = ST_RWAIT;
            end else begin
              state_d = ST_SUB;
            end
          end
        end
        ST_RX_ACK: begin
          if (scl_fall) begin
            sda_oe_d = 1'b0;
            state_d = ST_WDATA;
          end
        end
        ST_RWAIT: begin
          if (rd_valid) begin
            sh_d = rd_data;
            sda_oe_d = ~rd_data[7];
            scl_oe_d = 1'b0;
            cnt_d = 4'h0;
            state_d = ST_RDATA;
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (cnt_q == itas_pkg::BYTE_BITS) begin
              sda_oe_d = 1'b0;
              state_d = ST_RMACK;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              sda_oe_d = ~sh_q[6];
            end
          end
        end
        ST_RMACK: begin
          if (scl_rise) begin
            mack_d = ~sda_s2_q;
          end else if (scl_fall) begin
            if (mack_q) begin
              rd_req_d = 1'b1;
              scl_oe_d = 1'b1;
              state_d = ST_RWAIT;
            end else begin
              state_d = ST_IGNORE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      sub_q <= 8'h00;
      wdat_q <= 8'h00;
      ctx_q <= 1'b0;
      rw_q <= 1'b0;
      mack_q <= 1'b0;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
      wr_valid_q <= 1'b0;
      rd_req_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      sub_q <= sub_d;
      wdat_q <= wdat_d;
      ctx_q <= ctx_d;
      rw_q <= rw_d;
      mack_q <= mack_d;
      sda_oe_q <= sda_oe_d;
      scl_oe_q <= scl_oe_d;
      wr_valid_q <= wr_valid_d;
      rd_req_q <= rd_req_d;
    end
  end

  // Port interrupt and enable status
  logic irq_n_q, irq_n_d, en_q, en_d;

  always_comb begin
    irq_n_d = ~|(irq_event & irq_mask);
    en_d = aif.ready;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_n_q <= 1'b1;
      en_q <= 1'b0;
    end else begin
      irq_n_q <= irq_n_d;
      en_q <= en_d;
    end
  end

  // Open-drain pins only ever pull low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = scl_oe_q;
  assign sda_oe = sda_oe_q;
  assign port_enabled = en_q;
  assign wr_valid = wr_valid_q;
  assign wr_ctx = ctx_q;
  assign wr_sub = sub_q;
  assign wr_data = wdat_q;
  assign rd_req = rd_req_q;
  assign rd_ctx = ctx_q;
  assign rd_sub = sub_q;
  assign port_irq_n = irq_n_q;

endmodule

`default_nettype wire

// ### dv/itas_target_checker.sv
`timescale 1ns/10ps
`default_nettype none

module itas_target_checker #(
  parameter int EV_W = itas_pkg::EV_W_DEF
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic strap_valid,
  input wire logic port_enabled,
  input wire logic wr_valid,
  input wire logic rd_req,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  input wire logic [EV_W-1:0] irq_event,
  input wire logic [EV_W-1:0] irq_mask,
  input wire logic port_irq_n
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  // Port behaviour against its causes
  a_irq_level_tracks: assert property (!$past(reset) |->
    port_irq_n == !$past(|(irq_event & irq_mask))) else $error("irq wrong");
  a_enable_sticky: assert property (port_enabled |=> port_enabled)
    else $error("enable dropped");
  a_enable_cause: assert property ($rose(port_enabled) |->
    $past(strap_valid)) else $error("enable without strap");
  a_quiet_disabled: assert property (!port_enabled |->
    !(sda_oe | scl_oe | wr_valid | rd_req)) else $error("early activity");
  a_stretch_on_req: assert property (rd_req |-> scl_oe)
    else $error("no stretch on read request");
  a_stretch_hold: assert property (scl_oe && !rd_valid |=> scl_oe)
    else $error("stretch released early");
  a_read_msb_first: assert property (scl_oe && rd_valid |=>
    !scl_oe && sda_oe == !$past(rd_data[7])) else $error("read bit wrong");
  a_write_pulse_once: assert property (wr_valid |=> !wr_valid)
    else $error("write pulse too long");

  // Main scenarios reached
  c_write: cover property (wr_valid);
  c_read: cover property (rd_req);
  c_irq: cover property (!port_irq_n);
  c_long_stretch: cover property (scl_oe ##30 scl_oe);
endmodule

`default_nettype wire

// ### dv/itas_ctl_model.sv
`timescale 1ns/10ps
`default_nettype none

// Bus controller driving both lines through open-drain pulls
module itas_ctl_model (
  input wire logic ref_clk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_pull,
  output logic sda_pull
);
  int q = 25; // Quarter bit time in clocks
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end

  // Wait a number of clocks
  task automatic t(int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Start or repeated start: data falls while clock is high
  task automatic start();
    sda_pull <= 1'b0;
    t(q);
    scl_pull <= 1'b0;
    t(q);
    sda_pull <= 1'b1;
    t(q);
    scl_pull <= 1'b1;
    t(q);
  endtask

  // One bit; waits while the target stretches the clock
  task automatic bit1(input logic b, output logic r);
    sda_pull <= !b;
    t(q);
    scl_pull <= 1'b0;
    t(1);
    for (int k = 0; k < 5000 && !scl; k++) t(1);
    t(q);
    r = sda;
    t(q);
    scl_pull <= 1'b1;
    t(q);
  endtask

  // Eight bits MSB first, then the acknowledge slot
  task automatic xfer(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) bit1(d[i], r[i]);
  endtask

  // Stop: data rises while clock is high
  task automatic stop();
    sda_pull <= 1'b1;
    t(q);
    scl_pull <= 1'b0;
    t(q);
    sda_pull <= 1'b0;
    t(q);
  endtask
endmodule

`default_nettype wire

// ### dv/i2c_target_address_select_bench.sv
`timescale 1ns/10ps
`default_nettype none

module i2c_target_address_select_bench;
  localparam int FULL = (1 << itas_pkg::ADC_W_DEF) - 1;
  localparam logic [9:0] CODES [4] = '{10'h0B8, 10'h184, 10'h251, 10'h252};
  logic ref_clk = 1'b0, reset = 1'b1, strap_valid = 1'b0, rd_valid = 1'b0;
  logic [9:0] address_strap_input = 10'h000;
  logic [6:0] fw_mask_one = 7'h00, fw_value_one = 7'h00;
  logic [6:0] fw_mask_two = 7'h00, fw_value_two = 7'h00;
  logic [7:0] rd_data = 8'h00, irq_event = 8'h00, irq_mask = 8'h00;
  logic scl_out, scl_oe, sda_out, sda_oe, port_enabled, wr_valid, wr_ctx;
  logic rd_req, rd_ctx, port_irq_n, scl_pull, sda_pull;
  logic [7:0] wr_sub, wr_data, rd_sub, rd_byte;
  logic scl_out2, scl_oe2, sda_out2, sda_oe2, port_enabled2, wr_valid2;
  logic wr_ctx2, rd_req2, rd_ctx2, port_irq_n2;
  logic [7:0] wr_sub2, wr_data2, rd_sub2;
  logic [17:0] expq[$];
  logic [7:0] rdq[$];
  int error_cnt = 0, checks_done = 0, cyc = 0;
  // Open-drain lines: an enabled pin shows its driven value, else pull-up
  wire logic scl = !scl_pull & (scl_oe ? scl_out : 1'b1)
    & (scl_oe2 ? scl_out2 : 1'b1);
  wire logic sda = !sda_pull & (sda_oe ? sda_out : 1'b1)
    & (sda_oe2 ? sda_out2 : 1'b1);

  itas_target uut (.ref_clk, .reset, .scl_in(scl), .scl_out, .scl_oe,
    .sda_in(sda), .sda_out, .sda_oe, .strap_valid, .address_strap_input,
    .fw_mask_one, .fw_value_one, .fw_mask_two, .fw_value_two, .port_enabled,
    .wr_valid, .wr_ctx, .wr_sub, .wr_data, .rd_req, .rd_ctx, .rd_sub,
    .rd_valid, .rd_data, .irq_event, .irq_mask, .port_irq_n);
  // Secondary host port on the same bus, fixed addresses; it shares the
  // port-two override, whose bit 3 both fixed addresses already carry
  itas_target #(.USE_STRAP(1'b0)) uut2 (.ref_clk, .reset, .scl_in(scl),
    .scl_out(scl_out2), .scl_oe(scl_oe2), .sda_in(sda), .sda_out(sda_out2),
    .sda_oe(sda_oe2), .strap_valid, .address_strap_input,
    .fw_mask_one(fw_mask_two), .fw_value_one(fw_value_two),
    .fw_mask_two, .fw_value_two, .port_enabled(port_enabled2),
    .wr_valid(wr_valid2), .wr_ctx(wr_ctx2), .wr_sub(wr_sub2),
    .wr_data(wr_data2), .rd_req(rd_req2), .rd_ctx(rd_ctx2),
    .rd_sub(rd_sub2), .rd_valid, .rd_data, .irq_event, .irq_mask,
    .port_irq_n(port_irq_n2));
  itas_ctl_model ctl (.ref_clk, .scl, .sda, .scl_pull, .sda_pull);

  initial forever #5 ref_clk = !ref_clk;

  // Cuts a hang short
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      conclude();
    end
  end

  task automatic chk(string n, logic [17:0] e, logic [17:0] s);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Strap band from the ratio limits
  function automatic logic [1:0] band_of(int v);
    if (v * 1000 <= itas_pkg::BAND0_MAX_PM * FULL) return 2'h0;
    if (v * 1000 <= itas_pkg::BAND1_MAX_PM * FULL) return 2'h1;
    if (v * 1000 <= itas_pkg::BAND2_MAX_PM * FULL) return 2'h2;
    return 2'h3;
  endfunction

  // Reset, then present a strap reading
  task automatic boot(logic [9:0] code);
    reset <= 1'b1;
    strap_valid <= 1'b0;
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    address_strap_input <= code;
    @(posedge ref_clk);
    strap_valid <= 1'b1;
    for (int k = 0; k < 20 && !port_enabled; k++) @(posedge ref_clk);
    chk("enabled", 18'h1, port_enabled);
    chk("enabled two", 18'h1, port_enabled2);
  endtask

  // Address, sub-address, one data byte
  task automatic wr(logic [6:0] a, logic ctx, logic ack);
    logic [8:0] r;
    logic [7:0] sub;
    logic [7:0] dat;
    sub = 8'($urandom);
    dat = 8'($urandom);
    if (ack) expq.push_back({1'b0, ctx, sub, dat});
    ctl.start();
    ctl.xfer({a, 1'b0, 1'b1}, r);
    chk("addr ack", ack, !r[0]);
    ctl.xfer({sub, 1'b1}, r);
    chk("sub ack", ack, !r[0]);
    ctl.xfer({dat, 1'b1}, r);
    chk("data ack", ack, !r[0]);
    ctl.stop();
  endtask

  // Sub-address write, repeated start, two bytes read, last refused
  task automatic rd(logic [6:0] a, logic ctx);
    logic [8:0] r;
    logic [7:0] sub;
    sub = 8'($urandom);
    repeat (2) expq.push_back({1'b1, ctx, sub, 8'h00});
    ctl.start();
    ctl.xfer({a, 1'b0, 1'b1}, r);
    ctl.xfer({sub, 1'b1}, r);
    ctl.start();
    ctl.xfer({a, 1'b1, 1'b1}, r);
    chk("read addr ack", 18'h1, !r[0]);
    for (int i = 0; i < 2; i++) begin
      ctl.xfer({8'hFF, i[0]}, r);
      chk("read data", rdq.pop_front(), r[8:1]);
    end
    ctl.stop();
  endtask

  // Read source: answers each request after a random stall; port-one
  // reads stall past a quarter bit; the controller sees the stretch only when it outlasts its own half-bit low
  initial forever begin
    @(negedge ref_clk);
    if (rd_req === 1'b1) begin
      repeat ($urandom_range(1, 12) + (rd_ctx ? 0 : 40)) @(posedge ref_clk);
      rd_byte = 8'($urandom);
      rdq.push_back(rd_byte);
      rd_data <= rd_byte;
      rd_valid <= 1'b1;
      @(posedge ref_clk);
      rd_valid <= 1'b0;
    end
  end

  // Takes the oldest note whenever a transfer shows up
  initial forever begin
    logic [17:0] e;
    @(negedge ref_clk);
    if (wr_valid === 1'b1 || rd_req === 1'b1) begin
      e = expq.size() ? expq.pop_front() : 18'hXXXXX;
      chk("transfer", e, wr_valid ? {1'b0, wr_ctx, wr_sub, wr_data}
        : {1'b1, rd_ctx, rd_sub, 8'h00});
    end
    if (wr_valid2 === 1'b1 || rd_req2 === 1'b1) begin
      e = expq.size() ? expq.pop_front() : 18'hXXXXX;
      chk("secondary transfer", e,
        {rd_req2, wr_ctx2, wr_sub2, wr_data2});
    end
  end

  initial begin
    logic [1:0] bd;
    logic [6:0] a1, a2, ov;
    logic [7:0] ev, mk;
    void'($urandom(32'h7E66));
    for (int b = 0; b < 4; b++) begin
      boot(CODES[b]);
      bd = band_of(CODES[b]);
      wr({itas_pkg::ADDR_PRI_UPPER, b[0], bd}, b[0], 1'b1);
    end
    $display("test strap bands done");
    a1 = {itas_pkg::ADDR_PRI_UPPER, itas_pkg::CODE_SEL_ONE, bd};
    a2 = {itas_pkg::ADDR_PRI_UPPER, itas_pkg::CODE_SEL_TWO, bd};
    wr(itas_pkg::ADDR_SEC_ONE, 1'b0, 1'b1);
    wr(itas_pkg::ADDR_SEC_TWO, 1'b1, 1'b1);
    $display("test secondary done");
    wr(itas_pkg::ADDR_SEC_ONE ^ 7'h10, 1'b0, 1'b0);
    wr(a1 ^ 7'h01, 1'b0, 1'b0);
    $display("test unmatched done");
    ov = {3'h5, 4'($urandom)};
    fw_mask_one <= 7'h7F;
    fw_value_one <= ov;
    fw_mask_two <= 7'h08;
    fw_value_two <= 7'h08;
    @(posedge ref_clk);
    wr(ov, 1'b0, 1'b1);
    wr(a1, 1'b0, 1'b0);
    wr(a2 | 7'h08, 1'b1, 1'b1);
    fw_mask_one <= 7'h00;
    fw_mask_two <= 7'h00;
    $display("test override done");
    rd(a2, 1'b1);
    rd(a1, 1'b0);
    $display("test read done");
    ctl.q = 63;
    wr(a1, 1'b0, 1'b1);
    ctl.q = 250;
    wr(a2, 1'b1, 1'b1);
    $display("test rates done");
    for (int i = 0; i < 8; i++) begin
      ev = 8'($urandom);
      mk = i[0] ? 8'h00 : 8'($urandom);
      @(posedge ref_clk);
      irq_event <= ev;
      irq_mask <= mk;
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk("irq", !(|(ev & mk)), port_irq_n);
      chk("irq two", !(|(ev & mk)), port_irq_n2);
    end
    $display("test interrupt done");
    chk("leftover notes", 18'h0, 18'(expq.size()));
    conclude();
  end
endmodule

bind itas_target itas_target_checker #(.EV_W(EV_W)) chk (.ref_clk, .reset,
  .scl_oe, .sda_oe, .strap_valid, .port_enabled, .wr_valid, .rd_req,
  .rd_valid, .rd_data, .irq_event, .irq_mask, .port_irq_n);

`default_nettype wire
